//--- design/vah_defs.svh
// constants of the voltage angle hold block: timing, register map, limits
`ifndef VAH_DEFS_SVH
`define VAH_DEFS_SVH

`define VAH_CLK_NS        5
`define VAH_TICK_NS       10000000
`define VAH_PRE_W         24

`define VAH_ADDR_CTRL     8'h00
`define VAH_ADDR_VTHR     8'h04
`define VAH_ADDR_ITHR     8'h08
`define VAH_ADDR_TMAX     8'h0c
`define VAH_ADDR_STAT     8'h10

`define VAH_CTRL_ENABLE   0
`define VAH_CTRL_CUR_EN   1
`define VAH_CTRL_FIXED    2
`define VAH_CTRL_F60      3
`define VAH_CTRL_FORCED   4
`define VAH_STAT_HOLD     6

`define VAH_VTHR_MIN      16'h00c8
`define VAH_VTHR_MAX      16'h1388
`define VAH_VTHR_RST      16'h07d0
`define VAH_ITHR_RST      16'h03e8
`define VAH_TMAX_MIN      13'h0002
`define VAH_TMAX_MAX      13'h1388
`define VAH_TMAX_RST      13'h0064

`define VAH_FREQ_50       16'h1388
`define VAH_FREQ_60       16'h1770

`endif

//--- design/vah_dt_timer.sv
// definite-time limit counted in 10 ms ticks while run is high
`default_nettype none
`include "vah_defs.svh"

module vah_dt_timer
  import vah_pkg::*;
#(
  parameter int TICK_CYC = `VAH_TICK_NS / `VAH_CLK_NS
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic [12:0] limit,
  output logic             expired
);

  localparam logic [`VAH_PRE_W-1:0] PRE_LAST = `VAH_PRE_W'(TICK_CYC - 1);

  vah_tmr_st_t st;
  vah_tmr_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (!run)
    begin
      // prescaler restarts too, so the first tick is a full period
      next_st = '0;
    end
    else
    begin
      if (st.pre == PRE_LAST)
      begin
        next_st.pre = '0;
        if (st.ticks != 13'h1fff)
          next_st.ticks = st.ticks + 13'h0001;
      end
      else
        next_st.pre = st.pre + `VAH_PRE_W'(1);
      next_st.expired = (st.ticks >= limit);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign expired = st.expired;

endmodule : vah_dt_timer

`default_nettype wire

//--- design/vah_level_cmp.sv
// one level comparison, refreshed at each program cycle start
`default_nettype none
`include "vah_defs.svh"

module vah_level_cmp
  import vah_pkg::*;
#(
  parameter int W     = 16,
  parameter bit ABOVE = 1'b0
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         sample,
  input  wire logic         used,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] limit,
  output logic              hit
);

  vah_cmp_st_t st;
  vah_cmp_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (sample)
    begin
      // an unused channel must not veto "all low" nor fake "one high"
      if (!used)
        next_st.hit = ~ABOVE;
      else if (ABOVE)
        next_st.hit = (value > limit);
      else
        next_st.hit = (value < limit);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign hit = st.hit;

endmodule : vah_level_cmp

`default_nettype wire

//--- design/vah_pkg.sv
// state types of the voltage angle hold block
`default_nettype none
`include "vah_defs.svh"

package vah_pkg;

  typedef struct packed {
    logic hit;
  } vah_cmp_st_t;

  typedef struct packed {
    logic [`VAH_PRE_W-1:0] pre;
    logic [12:0]           ticks;
    logic                  expired;
  } vah_tmr_st_t;

  typedef struct packed {
    logic        enable;
    logic        cur_cond_en;
    logic        fixed_track;
    logic        fixed_60;
    logic        forced_ct;
    logic [15:0] vthr;
    logic [15:0] ithr;
    logic [12:0] tmax;
    logic        blk_m;
    logic        blk_s;
    logic        blocked;
    logic        cs_d;
    logic        active;
    logic        exp_hold;
    logic        ct_track;
    logic [5:0]  flags;
    logic [15:0] ang_now;
    logic [15:0] ang_pre;
    logic [15:0] ref_angle;
    logic [15:0] ref_amp;
    logic [15:0] samp_freq;
    logic [11:0] ev;
    logic [31:0] rdata;
  } vah_st_t;

endpackage : vah_pkg

`default_nettype wire

//--- design/vah_top.sv
// voltage angle hold: substitute voltage reference during collapsed voltages
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
`include "vah_defs.svh"

// Overview of operation
// - engage only when every used voltage is below the activation threshold
// - optional current qualifier: one phase current must also exceed its pick-up
// - activation threshold limited to 2 to 50 V
// - while engaged, output amplitude equals the activation threshold
// - reference angle is the one sampled one program cycle before engaging
// - in-use output is high whenever the hold is engaged
// - engaged time limited by a definite time of 0.02 to 50.00 s
// - after expiry stop the reference and signal non-directional fallback
// - block input sampled at each program cycle start, inhibits while high
// - fixed tracking uses a fixed 50 or 60 Hz sampling frequency
// - forced current tracking with voltages gone follows third phase current
// - on and off events for six conditions
// - configuration enable switches the function, never engages when off
module vah_top
  import vah_pkg::*;
#(
  parameter int TICK_CYC = `VAH_TICK_NS / `VAH_CLK_NS
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        cycle_start,
  input  wire logic [2:0]  volt_used,
  input  wire logic [15:0] volt_mag0,
  input  wire logic [15:0] volt_mag1,
  input  wire logic [15:0] volt_mag2,
  input  wire logic [15:0] volt_angle,
  input  wire logic [15:0] cur_mag0,
  input  wire logic [15:0] cur_mag1,
  input  wire logic [15:0] third_phase_current,
  input  wire logic [15:0] volt_freq,
  input  wire logic [15:0] third_phase_freq,
  input  wire logic        block_in,
  output logic             voltage_angle_hold_in_use,
  output logic             ref_valid,
  output logic      [15:0] ref_amp,
  output logic      [15:0] ref_angle,
  output logic             nondir_fallback,
  output logic      [15:0] samp_freq,
  output logic      [11:0] vt_module_event_group
);

  vah_st_t st;
  vah_st_t next_st;

  logic [2:0]  v_low;
  logic [2:0]  i_high;
  logic [15:0] v_mag [3];
  logic [15:0] i_mag [3];
  logic        expired;
  logic        all_low;
  logic        any_high;
  logic        cond;
  logic [15:0] wr_vthr;
  logic [12:0] wr_tmax;

  assign v_mag[0] = volt_mag0;
  assign v_mag[1] = volt_mag1;
  assign v_mag[2] = volt_mag2;
  assign i_mag[0] = cur_mag0;
  assign i_mag[1] = cur_mag1;
  assign i_mag[2] = third_phase_current;

  // currents are always judged: the qualifier has no per-phase use mask
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_level
      vah_level_cmp #(
        .W     (16),
        .ABOVE (1'b0)
      ) u_vlow (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .sample   (cycle_start),
        .used     (volt_used[g]),
        .value    (v_mag[g]),
        .limit    (st.vthr),
        .hit      (v_low[g])
      );
      vah_level_cmp #(
        .W     (16),
        .ABOVE (1'b1)
      ) u_ihigh (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .sample   (cycle_start),
        .used     (1'b1),
        .value    (i_mag[g]),
        .limit    (st.ithr),
        .hit      (i_high[g])
      );
    end
  endgenerate

  // timer restarts from zero on every engage, never resumes a partial count
  vah_dt_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (st.active),
    .limit    (st.tmax),
    .expired  (expired)
  );

  // no used channel at all means nothing to judge, so never engage
  // current qualifier off: the voltage condition alone decides
  assign all_low  = (&v_low) && (volt_used != 3'b000);
  assign any_high = |i_high;
  assign cond     = st.enable && all_low &&
                    (!st.cur_cond_en || any_high);

  // voltage threshold and time writes are clamped into their legal ranges;
  // clamping rather than refusing means a bad write still leaves a usable setting
  always_comb
  begin
    wr_vthr = wdata[15:0];
    if (wr_vthr < `VAH_VTHR_MIN)
      wr_vthr = `VAH_VTHR_MIN;
    else if (wr_vthr > `VAH_VTHR_MAX)
      wr_vthr = `VAH_VTHR_MAX;
    wr_tmax = wdata[12:0];
    if (wdata[31:13] != 19'h00000 || wr_tmax > `VAH_TMAX_MAX)
      wr_tmax = `VAH_TMAX_MAX;
    else if (wr_tmax < `VAH_TMAX_MIN)
      wr_tmax = `VAH_TMAX_MIN;
  end

  always_comb
  begin
    next_st = st;
    next_st.ev = '0;
    next_st.cs_d = cycle_start;

    // register writes
    if (wr)
    begin
      case (addr)
        `VAH_ADDR_CTRL:
        begin
          next_st.enable      = wdata[`VAH_CTRL_ENABLE];
          next_st.cur_cond_en = wdata[`VAH_CTRL_CUR_EN];
          next_st.fixed_track = wdata[`VAH_CTRL_FIXED];
          next_st.fixed_60    = wdata[`VAH_CTRL_F60];
          next_st.forced_ct   = wdata[`VAH_CTRL_FORCED];
        end
        `VAH_ADDR_VTHR: next_st.vthr = wr_vthr;
        `VAH_ADDR_ITHR: next_st.ithr = wdata[15:0];
        `VAH_ADDR_TMAX: next_st.tmax = wr_tmax;
        default: ;
      endcase
    end

    // block pin synchroniser, then sampled once per program cycle;
    // limitation: a block pulse that falls between two cycle starts is never seen
    next_st.blk_m = block_in;
    next_st.blk_s = st.blk_m;
    if (cycle_start)
      next_st.blocked = st.blk_s;

    // pre-fault angle history is frozen while engaged;
    // two deep because the newest sample may already carry the collapse,
    // so the older one is the last healthy angle
    if (cycle_start && !st.active)
    begin
      next_st.ang_now = volt_angle;
      next_st.ang_pre = st.ang_now;
    end

    // engage and release are judged one clock after cycle start,
    // once the comparators hold this cycle's result
    if (st.cs_d)
    begin
      if (!cond)
      begin
        next_st.active   = 1'b0;
        next_st.exp_hold = 1'b0;
      end
      else if (!st.active && !st.blocked && !st.exp_hold)
      begin
        next_st.active    = 1'b1;
        next_st.ref_angle = st.ang_pre;
      end
    end
    if (st.blocked)
      next_st.active = 1'b0;
    if (!st.enable)
    begin
      next_st.active   = 1'b0;
      next_st.exp_hold = 1'b0;
    end

    // expiry wins over everything and latches until conditions clear;
    // re-engaging straight away would restart directional tripping on a
    // stale angle, so the stages stay non-directional instead
    if (st.active && expired)
    begin
      next_st.active   = 1'b0;
      next_st.exp_hold = 1'b1;
    end

    // amplitude follows the threshold setting while engaged,
    // however far the measured voltages have fallen
    next_st.ref_amp = next_st.active ? st.vthr : 16'h0000;
    if (!next_st.active)
      next_st.ref_angle = 16'h0000;

    // sampling frequency selection for every stage but frequency protection,
    // which keeps its own tracking outside this block;
    // fixed tracking can follow the current once voltages are gone
    next_st.ct_track = st.fixed_track && st.forced_ct &&
                       st.enable && all_low;
    if (!st.fixed_track)
      next_st.samp_freq = volt_freq;
    else if (next_st.ct_track)
      next_st.samp_freq = third_phase_freq;
    else if (st.fixed_60)
      next_st.samp_freq = `VAH_FREQ_60;
    else
      next_st.samp_freq = `VAH_FREQ_50;

    // event flags: rise gives the on event, fall the off event;
    // pair order: enabled, low voltage, high current,
    // frequency from current, in use, blocked
    next_st.flags[0] = next_st.enable;
    next_st.flags[1] = st.enable && all_low;
    next_st.flags[2] = st.enable && any_high;
    next_st.flags[3] = next_st.ct_track;
    next_st.flags[4] = next_st.active;
    next_st.flags[5] = st.enable && next_st.blocked;
    for (int k = 0; k < 6; k++)
    begin
      next_st.ev[2*k]   = next_st.flags[k] && !st.flags[k];
      next_st.ev[2*k+1] = !next_st.flags[k] && st.flags[k];
    end

    // register reads, data valid in the following cycle only;
    // status word: bits 5..0 the event flags, then the expiry hold
    next_st.rdata = 32'h00000000;
    if (rd)
    begin
      case (addr)
        `VAH_ADDR_CTRL:
        begin
          next_st.rdata[`VAH_CTRL_ENABLE] = st.enable;
          next_st.rdata[`VAH_CTRL_CUR_EN] = st.cur_cond_en;
          next_st.rdata[`VAH_CTRL_FIXED]  = st.fixed_track;
          next_st.rdata[`VAH_CTRL_F60]    = st.fixed_60;
          next_st.rdata[`VAH_CTRL_FORCED] = st.forced_ct;
        end
        `VAH_ADDR_VTHR: next_st.rdata[15:0] = st.vthr;
        `VAH_ADDR_ITHR: next_st.rdata[15:0] = st.ithr;
        `VAH_ADDR_TMAX: next_st.rdata[12:0] = st.tmax;
        `VAH_ADDR_STAT:
        begin
          next_st.rdata[5:0] = st.flags;
          next_st.rdata[`VAH_STAT_HOLD] = st.exp_hold;
        end
        default: ;
      endcase
    end
  end

  // settings return to their defaults on reset; never engaged out of reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st             <= '0;
      st.vthr        <= `VAH_VTHR_RST;
      st.ithr        <= `VAH_ITHR_RST;
      st.tmax        <= `VAH_TMAX_RST;
      st.samp_freq   <= `VAH_FREQ_50;
    end
    else
      st <= next_st;
  end

  // every output straight from the state register
  assign rdata                     = st.rdata;
  assign voltage_angle_hold_in_use = st.active;
  assign ref_valid                 = st.active;
  assign ref_amp                   = st.ref_amp;
  assign ref_angle                 = st.ref_angle;
  assign nondir_fallback           = st.exp_hold;
  assign samp_freq                 = st.samp_freq;
  assign vt_module_event_group     = st.ev;

endmodule : vah_top

`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the voltage angle hold block
`default_nettype none
`include "vah_defs.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 10;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0, cs = 1'b0, blk = 1'b0, iu, rv, fb, q, en;
  logic [2:0] vu = 3'h7;
  logic [15:0] m0, m1, m2, ang, c0, c1, c2, vf, tf, ramp, rang, sf, sang, vthr, ithr, pre;
  logic [31:0] rdata, d;
  logic [11:0] ev, evseen = 12'h0;
  logic [1:0] smode;
  int failures = 0, total_checks = 0, cyc = 0, n, seed = 32'h0682455e;
  logic [31:0] tab [4][3] = '{'{4, 1, 200}, '{4, 32'hffff, 5000}, '{12, 0, 2}, '{12, 32'h2000, 5000}};
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) evseen <= rst_b ? (evseen | ev) : 12'h000;
  vah_top #(.TICK_CYC(TK)) DUT (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cycle_start(cs), .volt_used(vu), .volt_mag0(m0), .volt_mag1(m1), .volt_mag2(m2),
    .volt_angle(ang), .cur_mag0(c0), .cur_mag1(c1), .third_phase_current(c2), .volt_freq(vf),
    .third_phase_freq(tf), .block_in(blk), .voltage_angle_hold_in_use(iu), .ref_valid(rv), .ref_amp(ramp),
    .ref_angle(rang), .nondir_fallback(fb), .samp_freq(sf), .vt_module_event_group(ev));
  vah_stage_model u_stage (.core_clk(core_clk), .rst_b(rst_b), .ref_valid(rv), .ref_angle(rang),
    .nondir_fallback(fb), .mode(smode), .used_angle(sang));
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rreg
  task automatic tick(input int k);
    @(posedge core_clk);
    cs <= 1'b1;
    @(posedge core_clk);
    cs <= 1'b0;
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic setv(input logic [2:0] u, input logic [15:0] a, b, c, g);
    @(posedge core_clk);
    vu <= u;
    {m0, m1, m2, ang} <= {a, b, c, g};
  endtask : setv
  function automatic logic [15:0] near(input logic [15:0] t);
    case ({$random(seed)} % 4)
      0: return t - 16'h1;
      1: return t;
      2: return t + 16'h1;
      default: return {$random(seed)} % (2 * t);
    endcase
  endfunction : near
  function automatic logic exp_on(input logic [2:0] u);
    logic lo;
    lo = (u != 0) && (!u[0] || m0 < vthr) && (!u[1] || m1 < vthr) && (!u[2] || m2 < vthr);
    return en && lo && (!q || c0 > ithr || c1 > ithr || c2 > ithr);
  endfunction : exp_on
  function automatic logic [15:0] exp_freq(input logic [4:0] k, input logic low);
    if (!k[2])
      return vf;
    if (k[4] && k[0] && low)
      return tf;
    return k[3] ? `VAH_FREQ_60 : `VAH_FREQ_50;
  endfunction : exp_freq
  initial
  begin
    {m0, m1, m2, ang, c0, c1, c2} = {7{16'hffff}};
    vf = 16'h1000 + {$random(seed)} % 16'h0800;
    tf = vf + 16'h0123;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    `CHK("freq_rst", `VAH_FREQ_50, sf)
    foreach (tab[i])
    begin
      rreg(8'(i * 4 + (i / 4) * 16), d);
      `CHK("reset_val", (i == 1) ? 32'h7d0 : (i == 2) ? 32'h3e8 : (i == 3) ? 32'h64 : 32'h0, d)
    end
    foreach (tab[i])
    begin
      wreg(8'(tab[i][0]), tab[i][1]);
      rreg(8'(tab[i][0]), d);
      `CHK("clamp", tab[i][2], d)
    end
    wreg(8'h20, 32'h1);
    rreg(8'h20, d);
    `CHK("unmapped", 32'h0, d)
    vthr = 16'h00c8 + {$random(seed)} % 16'd4801;
    ithr = 16'h0010 + {$random(seed)} % 16'h2000;
    wreg(`VAH_ADDR_VTHR, {16'h0, vthr});
    wreg(`VAH_ADDR_ITHR, {16'h0, ithr});
    wreg(`VAH_ADDR_TMAX, 32'h64);
    $display("test regs done");
    for (int i = 0; i < 60; i++)
    begin
      {q, en} = 2'($random(seed)) | {1'b0, i > 5};
      wreg(`VAH_ADDR_CTRL, {30'h0, q, en});
      pre = $random(seed);
      setv(3'h7, 16'hffff, 16'hffff, 16'hffff, pre);
      // a stretch still engaged freezes the angle history, so give it a second cycle
      repeat (2) tick(2);
      `CHK("released", 1'b0, iu)
      setv($random(seed), near(vthr), near(vthr), near(vthr), $random(seed));
      {c0, c1, c2} <= {near(ithr), near(ithr), near(ithr)};
      tick(2);
      `CHK("engaged", exp_on(vu), iu)
      `CHK("amp", iu ? vthr : 16'h0, ramp)
      `CHK("angle", iu ? pre : 16'h0, rang)
      if (iu === 1'b1)
        `CHK("stage_use", {2'h1, pre}, {smode, sang})
    end
    $display("test random engage done");
    wreg(`VAH_ADDR_TMAX, 32'h2);
    wreg(`VAH_ADDR_CTRL, 32'h1);
    setv(3'h7, 16'hffff, 16'hffff, 16'hffff, 16'h0);
    tick(2);
    setv(3'h7, 16'h0, 16'h0, 16'h0, 16'h0);
    tick(2);
    `CHK("eng_exp", 1'b1, iu)
    for (n = 0; iu === 1'b1 && n < 100; n++)
      @(posedge core_clk) #1;
    `CHK("expiry_len", 1'b1, n >= 2 * TK - 1 && n <= 2 * TK + 3)
    tick(2);
    `CHK("fallback", 2'b10, {fb, iu})
    `CHK("stage_mode", 2'h2, smode)
    rreg(`VAH_ADDR_STAT, d);
    `CHK("stat_hold", 4'b1011, {d[6], d[4], d[1], d[0]})
    setv(3'h7, 16'hffff, 16'hffff, 16'hffff, 16'h0);
    tick(2);
    `CHK("fb_clear", 1'b0, fb)
    $display("test expiry done");
    wreg(`VAH_ADDR_TMAX, 32'h64);
    setv(3'h7, 16'h0, 16'h0, 16'h0, 16'h0);
    tick(2);
    @(posedge core_clk) blk <= 1'b1;
    repeat (8) @(posedge core_clk);
    tick(2);
    `CHK("blocked", 1'b0, iu)
    tick(2);
    `CHK("still_blk", 1'b0, iu)
    @(posedge core_clk) blk <= 1'b0;
    repeat (4) @(posedge core_clk);
    tick(2);
    `CHK("unblocked", 1'b1, iu)
    $display("test block done");
    for (int lo = 1; lo >= 0; lo--)
    begin
      setv(3'h7, lo ? 16'h0 : 16'hffff, 16'h0, 16'h0, 16'h0);
      for (int k = 0; k < 32; k++)
      begin
        wreg(`VAH_ADDR_CTRL, k);
        tick(2);
        `CHK("samp_freq", exp_freq(k, lo), sf)
      end
    end
    wreg(`VAH_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    `CHK("events", 12'hfff, evseen)
    $display("test freq and events done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

//--- verification/vah_checker.sv
// port-level assertions for the voltage angle hold top
`default_nettype none
module vah_checker
#(
  parameter int TICK_CYC = 10
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        cycle_start,
  input  wire logic        block_in,
  input  wire logic        voltage_angle_hold_in_use,
  input  wire logic        ref_valid,
  input  wire logic [15:0] ref_amp,
  input  wire logic [15:0] ref_angle,
  input  wire logic        nondir_fallback,
  input  wire logic [11:0] vt_module_event_group
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MAX_RUN = 5000 * TICK_CYC + 4;
  logic        iu;
  logic [31:0] run_cnt;
  assign iu = voltage_angle_hold_in_use;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // length of the present engaged stretch
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      run_cnt <= '0;
    else if (iu)
      run_cnt <= run_cnt + 32'h1;
    else
      run_cnt <= '0;
  end
  a_valid_pair:   assert property (iu == ref_valid) else $error("ref valid differs from in use");
  a_amp_idle:     assert property (!iu |-> ref_amp == 16'h0000) else $error("amplitude while idle");
  a_amp_steady:   assert property (iu && $past(iu) |-> $stable(ref_amp)) else $error("amplitude moved");
  a_angle_steady: assert property (iu && $past(iu) |-> $stable(ref_angle)) else $error("angle moved");
  a_engage_cs:    assert property ($rose(iu) |-> $past(cycle_start, 2)) else $error("engage off cycle");
  a_block_stops:  assert property (block_in [*8] ##0 cycle_start |-> ##2 !iu) else $error("not blocked");
  a_use_events:   assert property ($rose(iu) |-> vt_module_event_group[8]) else $error("no in use event");
  a_free_event:   assert property ($fell(iu) |-> vt_module_event_group[9]) else $error("no release event");
  a_fallback_off: assert property (nondir_fallback |-> !iu) else $error("fallback while engaged");
  a_fallback_src: assert property ($rose(nondir_fallback) |-> $past(iu)) else $error("fallback no cause");
  a_max_run:      assert property (run_cnt <= MAX_RUN) else $error("engaged too long");
  c_engage:   cover property ($rose(iu));
  c_fallback: cover property ($rose(nondir_fallback));
  c_blocked:  cover property (block_in && $fell(iu));
endmodule : vah_checker

bind vah_top vah_checker #(.TICK_CYC(TICK_CYC)) u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .cycle_start(cycle_start), .block_in(block_in), .voltage_angle_hold_in_use(voltage_angle_hold_in_use),
  .ref_valid(ref_valid), .ref_amp(ref_amp), .ref_angle(ref_angle), .nondir_fallback(nondir_fallback),
  .vt_module_event_group(vt_module_event_group));
`default_nettype wire

//--- verification/vah_stage_model.sv
// directional stage model consuming the substitute reference
`default_nettype none
module vah_stage_model
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        ref_valid,
  input  wire logic [15:0] ref_angle,
  input  wire logic        nondir_fallback,
  output logic      [1:0]  mode,
  output logic      [15:0] used_angle
);
  timeunit 1ns;
  timeprecision 100ps;
  // mode 1 directional on the held angle, 2 non-directional
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode <= 2'h0;
    else
      mode <= nondir_fallback ? 2'h2 : {1'b0, ref_valid};
  end
  always_ff @(posedge core_clk)
  begin
    if (ref_valid)
      used_angle <= ref_angle;
  end
endmodule : vah_stage_model
`default_nettype wire
